// ===== cfsen_pkg.sv
// Purpose: Shared constants and types for the clock fan-out serial enable.
// Assumes: 50 MHz core clock on both ends.
// Notes:   Holds bus address, register reset values and timing counts.
package cfsen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 20;
  // Quarter of one serial clock period, giving a 100 kHz bus clock.
  localparam int QTR_TIME_NS   = 2500;
  localparam int QTR_CYC       = QTR_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Serial protocol.
  localparam logic [7:0] ADDR_WRITE   = 8'hD2;
  localparam int         BYTE_BITS    = 8;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [2:0] IDX_CMD      = 3'h0;
  localparam logic [2:0] IDX_COUNT    = 3'h1;
  localparam logic [2:0] IDX_GRP0     = 3'h2;
  localparam logic [2:0] IDX_GRP1     = 3'h3;
  localparam logic [2:0] IDX_GRP2     = 3'h4;
  localparam logic [2:0] IDX_BEYOND   = 3'h5;
  localparam logic [7:0] HOST_CMD     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Output enable groups.
  localparam int         NUM_OUTS     = 10;
  localparam logic [7:0] GRP0_RESET   = 8'h0F;
  localparam logic [7:0] GRP1_RESET   = 8'hF0;
  localparam logic [7:0] GRP2_RESET   = 8'hC0;
  localparam int         GRP0_LSB     = 0;
  localparam int         GRP1_LSB     = 4;
  localparam int         GRP2_LSB     = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Device end state.
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ADDR, DEV_ACK_ADDR, DEV_DATA, DEV_ACK_DATA, DEV_IGNORE
  } cfsen_dev_fsm_t;

  typedef struct packed {
    logic [2:0]     scl_s;
    logic [2:0]     sda_s;
    logic [2:0]     ref_s;
    logic [2:0]     oe_s;
    logic           scl_f;
    logic           sda_f;
    logic           ref_f;
    logic           oe_f;
    cfsen_dev_fsm_t fsm;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic [2:0]     byte_idx;
    logic [7:0]     grp0;
    logic [7:0]     grp1;
    logic [7:0]     grp2;
    logic           sda_oe;
    logic [9:0]     clk_out;
    logic [9:0]     clk_oe;
  } cfsen_dev_t;

  ////////////////////////////////////////////////////////////////////////////
  // Host end state.
  typedef enum logic [1:0] {
    HST_IDLE, HST_START, HST_BIT, HST_STOP
  } cfsen_hst_fsm_t;

  typedef struct packed {
    logic [2:0]     sda_s;
    logic           sda_f;
    cfsen_hst_fsm_t fsm;
    logic [7:0]     tick;
    logic [1:0]     phase;
    logic [3:0]     bit_idx;
    logic [2:0]     byte_idx;
    logic [2:0]     last_idx;
    logic [7:0]     data0;
    logic [7:0]     data1;
    logic [7:0]     data2;
    logic [1:0]     count;
    logic           scl_oe;
    logic           sda_oe;
    logic           ready;
    logic           done;
    logic           nack;
  } cfsen_hst_t;

endpackage

// ===== cfsen_if.sv
// Purpose: Two-wire bus between the host end and the device end.
// Assumes: Both lines have pull-ups; every driver only pulls low.
// Notes:   Line levels are resolved here from the output enables.
`timescale 1ns/100ps
`default_nettype none

interface cfsen_if;

  // Host drivers.
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  // Device drivers.
  logic dev_sda_o;
  logic dev_sda_oe;
  // Resolved line levels.
  logic serial_clock_line;
  logic serial_data_line;

  assign serial_clock_line = host_scl_oe ? host_scl_o : 1'b1;
  assign serial_data_line  = (host_sda_oe ? host_sda_o : 1'b1) &
                             (dev_sda_oe  ? dev_sda_o  : 1'b1);

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input  serial_clock_line, serial_data_line
  );

  modport device (
    output dev_sda_o, dev_sda_oe,
    input  serial_clock_line, serial_data_line
  );

endinterface

`default_nettype wire

// ===== cfsen_host.sv
// Purpose: Bus master that writes the enable bytes of the fan-out buffer.
// Assumes: One write per command; the bus clock comes from a divider.
// Notes:   No clock stretching is honoured; the device never stretches.
`timescale 1ns/100ps
`default_nettype none

module cfsen_host
  import cfsen_pkg::*;
(
  // System.
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Serial bus.
  cfsen_if.host           bus,
  // Command.
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_count,
  input  wire logic [7:0] cmd_output_enable_group0,
  input  wire logic [7:0] cmd_output_enable_group1,
  input  wire logic [7:0] cmd_output_enable_group2,
  output logic            cmd_ready,
  // Status.
  output logic            done,
  output logic            nack
);

  cfsen_hst_t r;
  cfsen_hst_t n;
  logic       tick_hit;
  logic [7:0] cur_byte;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n        = r;
    tick_hit = (r.tick == QTR_LAST);
    n.sda_s  = {r.sda_s[1:0], bus.serial_data_line};
    if (r.sda_s[1] == r.sda_s[2]) begin
      n.sda_f = r.sda_s[2];
    end
    n.done   = 1'b0;
    n.tick   = (r.fsm == HST_IDLE || tick_hit) ? 8'h00 : r.tick + 8'h01;
    unique case (r.byte_idx)
      3'h0:    cur_byte = ADDR_WRITE;
      3'h1:    cur_byte = HOST_CMD;
      3'h2:    cur_byte = {6'h00, r.count};
      3'h3:    cur_byte = r.data0;
      3'h4:    cur_byte = r.data1;
      default: cur_byte = r.data2;
    endcase
    unique case (r.fsm)
      HST_IDLE: begin
        if (cmd_valid) begin
          n.fsm      = HST_START;
          n.ready    = 1'b0;
          n.nack     = 1'b0;
          n.phase    = 2'h0;
          n.count    = cmd_count;
          n.data0    = cmd_output_enable_group0;
          n.data1    = cmd_output_enable_group1;
          n.data2    = cmd_output_enable_group2;
          // Every earlier byte is always sent: no sub-addressing.
          n.last_idx = 3'(3'h2 + {1'b0, cmd_count});
        end
      end
      HST_START: begin
        if (tick_hit) begin
          n.phase = r.phase + 2'h1;
          if (r.phase == 2'h0) begin
            n.sda_oe = 1'b1;
          end else if (r.phase == 2'h1) begin
            n.scl_oe   = 1'b1;
            n.fsm      = HST_BIT;
            n.phase    = 2'h0;
            n.bit_idx  = 4'h0;
            n.byte_idx = 3'h0;
          end
        end
      end
      HST_BIT: begin
        if (tick_hit) begin
          n.phase = r.phase + 2'h1;
          unique case (r.phase)
            2'h0: begin
              // Data moves only while the clock is low.
              if (r.bit_idx == ACK_BIT) begin
                n.sda_oe = 1'b0;
              end else begin
                n.sda_oe = ~cur_byte[3'(7 - r.bit_idx)];
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (r.bit_idx == ACK_BIT && r.sda_f) begin
                n.nack = 1'b1;
              end
            end
            2'h3: begin
              n.scl_oe  = 1'b1;
              n.bit_idx = r.bit_idx + 4'h1;
              if (r.bit_idx == ACK_BIT) begin
                n.bit_idx  = 4'h0;
                n.byte_idx = r.byte_idx + 3'h1;
                if (r.nack || r.byte_idx == r.last_idx) begin
                  n.fsm = HST_STOP;
                end
              end
            end
          endcase
        end
      end
      HST_STOP: begin
        if (tick_hit) begin
          n.phase = r.phase + 2'h1;
          unique case (r.phase)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            2'h3: begin
              n.fsm   = HST_IDLE;
              n.ready = 1'b1;
              n.done  = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r       <= '0;
      r.sda_s <= 3'h7;
      r.sda_f <= 1'b1;
      r.fsm   <= HST_IDLE;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_oe = r.sda_oe;
  assign cmd_ready       = r.ready;
  assign done            = r.done;
  assign nack            = r.nack;

endmodule

`default_nettype wire

// ===== cfsen_device.sv
// Purpose: Write-only serial slave steering ten copies of one clock.
// Assumes: Bus lines and reference clock are sampled by core_clk.
// Notes:   Outputs follow the reference a few core cycles late.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Answer only to write address byte D2.
// - Slave receiver only; reads get nothing.
// - Master sends all earlier bytes, in order.
// - Bytes are eight bits MSB first, then acknowledge.
// - Master changes data only while clock low.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - First byte: seven-bit address plus direction bit.
// - Acknowledge own address; take bytes until start/stop.
// - Command and count bytes ignored but acknowledged.
// - First byte bits 0-3 enable outputs 0-3.
// - Second byte bits 4-7 enable outputs 4-7.
// - Third byte bits 7,6 enable outputs 9,8.
// - Enable one switches; zero holds output low.
// - At power-up all ten outputs are enabled.
// - Tri-state pin low floats all ten outputs.
// - Ten non-inverted copies of the reference.
module cfsen_device
  import cfsen_pkg::*;
(
  // System.
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial bus.
  cfsen_if.device          bus,
  // Reference clock and tri-state control.
  input  wire logic        ref_clk_in,
  input  wire logic        fanout_oe,
  // Clock outputs.
  output logic [9:0]       clk_out,
  output logic [9:0]       clk_out_oe
);

  cfsen_dev_t r;
  cfsen_dev_t n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [9:0] enable;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. A level change is taken only once the second and
  // third stages agree, which also rejects a one-sample glitch on the bus.
  always_comb begin
    n       = r;
    n.scl_s = {r.scl_s[1:0], bus.serial_clock_line};
    n.sda_s = {r.sda_s[1:0], bus.serial_data_line};
    n.ref_s = {r.ref_s[1:0], ref_clk_in};
    n.oe_s  = {r.oe_s[1:0], fanout_oe};
    if (r.scl_s[1] == r.scl_s[2]) begin
      n.scl_f = r.scl_s[2];
    end
    if (r.sda_s[1] == r.sda_s[2]) begin
      n.sda_f = r.sda_s[2];
    end
    if (r.ref_s[1] == r.ref_s[2]) begin
      n.ref_f = r.ref_s[2];
    end
    if (r.oe_s[1] == r.oe_s[2]) begin
      n.oe_f = r.oe_s[2];
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus events on the filtered lines.
    scl_rise   = n.scl_f & ~r.scl_f;
    scl_fall   = ~n.scl_f & r.scl_f;
    start_seen = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
    stop_seen  = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;

    //////////////////////////////////////////////////////////////////////////
    // Byte receiver.
    if (start_seen) begin
      // A repeated start aborts whatever byte was in flight.
      n.fsm     = DEV_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_oe  = 1'b0;
    end else if (stop_seen) begin
      n.fsm     = DEV_IDLE;
      n.sda_oe  = 1'b0;
    end else begin
      unique case (r.fsm)
        DEV_IDLE, DEV_IGNORE: begin
          n.sda_oe = 1'b0;
        end
        DEV_ADDR, DEV_DATA: begin
          if (scl_rise && r.bit_cnt < 4'(BYTE_BITS)) begin
            // Sampled at the rising edge, first bit is the MSB.
            n.shift   = {r.shift[6:0], n.sda_f};
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == 4'(BYTE_BITS)) begin
            n.bit_cnt = 4'h0;
            if (r.fsm == DEV_ADDR) begin
              // Address and direction bit must match the write byte.
              if (r.shift == ADDR_WRITE) begin
                n.fsm    = DEV_ACK_ADDR;
                n.sda_oe = 1'b1;
              end else begin
                // Reads and other addresses get no acknowledge.
                n.fsm = DEV_IGNORE;
              end
            end else begin
              n.fsm    = DEV_ACK_DATA;
              n.sda_oe = 1'b1;
            end
          end
        end
        DEV_ACK_ADDR: begin
          if (scl_fall) begin
            n.sda_oe   = 1'b0;
            n.fsm      = DEV_DATA;
            n.byte_idx = IDX_CMD;
          end
        end
        DEV_ACK_DATA: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.fsm    = DEV_DATA;
            // Commit at the end of the acknowledge pulse, in fixed order.
            unique case (r.byte_idx)
              IDX_GRP0: n.grp0 = r.shift;
              IDX_GRP1: n.grp1 = r.shift;
              IDX_GRP2: n.grp2 = r.shift;
              default: ;
            endcase
            if (r.byte_idx != IDX_BEYOND) begin
              n.byte_idx = r.byte_idx + 3'h1;
            end
          end
        end
        default: begin
          n.fsm    = DEV_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Fan-out. Unconnected and reserved bits are stored but drive nothing.
    enable[3:0] = r.grp0[GRP0_LSB +: 4];
    enable[7:4] = r.grp1[GRP1_LSB +: 4];
    enable[8]   = r.grp2[GRP2_LSB];
    enable[9]   = r.grp2[GRP2_LSB + 1];
    // Disabled copies sit low rather than floating.
    n.clk_out = {NUM_OUTS{n.ref_f}} & enable;
    n.clk_oe  = {NUM_OUTS{n.oe_f}};
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r       <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.oe_s  <= 3'h7;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
      r.oe_f  <= 1'b1;
      r.fsm   <= DEV_IDLE;
      r.grp0  <= GRP0_RESET;
      r.grp1  <= GRP1_RESET;
      r.grp2  <= GRP2_RESET;
      r.clk_oe <= '1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The device only ever pulls the data line low.
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = r.sda_oe;
  assign clk_out        = r.clk_out;
  assign clk_out_oe     = r.clk_oe;

endmodule

`default_nettype wire

// ===== cfsen_checker.sv
// Purpose: Assertions on the two-wire bus and the fanned-out clocks.
// Assumes: Inputs are the bus interface lines and the device end pins.
// Notes:   Bounds allow for the three-flop filters on every input.
`timescale 1ns/100ps
`default_nettype none

module cfsen_checker (
  // System.
  input wire logic       core_clk,
  input wire logic       reset,
  // Serial bus.
  input wire logic       dev_sda_oe,
  input wire logic       serial_clock_line,
  input wire logic       serial_data_line,
  // Clock path.
  input wire logic       ref_clk_in,
  input wire logic       fanout_oe,
  input wire logic [9:0] clk_out,
  input wire logic [9:0] clk_out_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  ack_edge_a: assert property (
    $changed(dev_sda_oe) |-> !serial_clock_line)
    else $error("Acknowledge moved while the clock was high.");
  ack_hold_a: assert property (
    dev_sda_oe && serial_clock_line |=> dev_sda_oe)
    else $error("Acknowledge dropped during the clock pulse.");
  ack_release_a: assert property (
    $fell(serial_clock_line) && dev_sda_oe |-> ##[1:8] !dev_sda_oe)
    else $error("Acknowledge held past its bit.");
  start_quiet_a: assert property (
    $fell(serial_data_line) && serial_clock_line |-> !dev_sda_oe [*8])
    else $error("Device drove data right after a start.");

  ////////////////////////////////////////////////////////////////////////////
  // Outputs lag the pins through the filters, hence the windows.
  oe_off_a: assert property (
    $fell(fanout_oe) |-> ##[1:8] clk_out_oe == 10'h000)
    else $error("Outputs not floated after enable went low.");
  oe_on_a: assert property (
    $rose(fanout_oe) |-> ##[1:8] clk_out_oe == 10'h3FF)
    else $error("Outputs not driven after enable went high.");
  oe_same_a: assert property (
    clk_out_oe == 10'h000 || clk_out_oe == 10'h3FF)
    else $error("Output enables differ between outputs.");
  out_low_a: assert property (
    !ref_clk_in [*8] |-> clk_out == 10'h000)
    else $error("Output high while the reference is low.");
  power_up_a: assert property (
    $fell(reset) ##0 ref_clk_in [*8] |-> clk_out == 10'h3FF)
    else $error("Not every output follows the reference after reset.");
endmodule

`default_nettype wire

// ===== tb_clock_fanout_serial_enable.sv
// Purpose: Self-checking bench joining host end and device end.
// Assumes: Host sends the address, command and count bytes itself.
// Notes:   Reference is stepped by the bench so levels are settled.
`timescale 1ns/100ps
`default_nettype none

module tb_clock_fanout_serial_enable;
  import cfsen_pkg::*;

  logic       core_clk;
  logic       reset;
  logic       cmd_valid;
  logic [1:0] cmd_count;
  logic [7:0] cmd_output_enable_group0;
  logic [7:0] cmd_output_enable_group1;
  logic [7:0] cmd_output_enable_group2;
  logic       cmd_ready;
  logic       done;
  logic       nack;
  logic       ref_clk_in;
  logic       fanout_oe;
  logic [9:0] clk_out;
  logic [9:0] clk_out_oe;
  logic [7:0] g0;
  logic [7:0] g1;
  logic [7:0] g2;
  int         failures;
  int         n_checks;

  ////////////////////////////////////////////////////////////////////////////
  cfsen_if bus_if ();

  cfsen_host cfsen_host_i (
    .core_clk  (core_clk),
    .reset     (reset),
    .bus       (bus_if.host),
    .cmd_valid (cmd_valid),
    .cmd_count (cmd_count),
    .cmd_output_enable_group0 (cmd_output_enable_group0),
    .cmd_output_enable_group1 (cmd_output_enable_group1),
    .cmd_output_enable_group2 (cmd_output_enable_group2),
    .cmd_ready (cmd_ready),
    .done      (done),
    .nack      (nack)
  );

  cfsen_device cfsen_device_i (
    .core_clk   (core_clk),
    .reset      (reset),
    .bus        (bus_if.device),
    .ref_clk_in (ref_clk_in),
    .fanout_oe  (fanout_oe),
    .clk_out    (clk_out),
    .clk_out_oe (clk_out_oe)
  );

  cfsen_checker cfsen_checker_i (
    .core_clk          (core_clk),
    .reset             (reset),
    .dev_sda_oe        (bus_if.dev_sda_oe),
    .serial_clock_line (bus_if.serial_clock_line),
    .serial_data_line  (bus_if.serial_data_line),
    .ref_clk_in        (ref_clk_in),
    .fanout_oe         (fanout_oe),
    .clk_out           (clk_out),
    .clk_out_oe        (clk_out_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [9:0] en_of();
    return {g2[7], g2[6], g1[7:4], g0[3:0]};
  endfunction

  // Only the bytes actually sent may change; the rest keep old values.
  task automatic write_cfg(input logic [1:0] cnt, input logic [7:0] b0,
                           input logic [7:0] b1, input logic [7:0] b2);
    int n;
    cmd_count = cnt;
    cmd_output_enable_group0 = b0;
    cmd_output_enable_group1 = b1;
    cmd_output_enable_group2 = b2;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    chk(10'(cmd_ready), 10'h000);
    n = 0;
    // Sample one step after each edge so the one-cycle done pulse is
    // seen while it stands, not raced against its own register update.
    while (done !== 1'b1 && n < 40000) begin
      tick();
      n++;
    end
    chk(10'(done), 10'h001);
    chk(10'(cmd_ready), 10'h001);
    chk(10'(nack), 10'h000);
    if (cnt > 2'h0) g0 = b0;
    if (cnt > 2'h1) g1 = b1;
    if (cnt > 2'h2) g2 = b2;
  endtask

  task automatic check_out();
    ref_clk_in = 1'b1;
    repeat (8) tick();
    chk(clk_out, en_of());
    chk(clk_out_oe, 10'h3FF);
    ref_clk_in = 1'b0;
    repeat (8) tick();
    chk(clk_out, 10'h000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Three writes take about 70000 cycles; allow some margin.
  initial begin
    #1_800_000;
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_count = 2'h0;
    cmd_output_enable_group0 = 8'h00;
    cmd_output_enable_group1 = 8'h00;
    cmd_output_enable_group2 = 8'h00;
    ref_clk_in = 1'b1;
    fanout_oe = 1'b1;
    g0 = 8'h0F;
    g1 = 8'hF0;
    g2 = 8'hC0;
    repeat (8) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (8) tick();
    chk(clk_out, 10'h3FF);
    ref_clk_in = 1'b0;
    repeat (8) tick();
    // Unused and reserved bits set on purpose; they must not matter.
    write_cfg(2'h3, 8'hF5, 8'hAF, 8'h7F);
    check_out();
    write_cfg(2'h1, 8'h0A, 8'h00, 8'h00);
    check_out();
    write_cfg(2'h2, 8'h03, 8'h50, 8'h00);
    check_out();
    fanout_oe = 1'b0;
    repeat (8) tick();
    chk(clk_out_oe, 10'h000);
    fanout_oe = 1'b1;
    repeat (8) tick();
    chk(clk_out_oe, 10'h3FF);
    tally_and_finish();
  end
endmodule

`default_nettype wire
